// [core/cfda_core.sv]
// Fetch and execute timing plus data addressing of an 8-bit core.
// Assumes a program store that answers combinationally to the address,
// and special function registers outside that answer on the same clock.
//
// Functional notes
// - System clock halved into two phases per cycle.
// - Counter moves first phase; fetch latched second.
// - Latched word executes in the following cycle.
// - Branch flushes the fetched word; costs two cycles.
// - Two data spaces; secondary space is write-only.
// - Secondary store copies accumulator, direct address.
// - Low main addresses are registers; SRAM above.
// - Main space reached directly or through pointer.
// - Indirect location redirects to pointer-addressed register.
// - Bit operations only on lower half.
// - Two RAM banks chosen by status bit five.
// - Bank SRAM spans start up to end address.
// - Main load puts addressed byte into accumulator.
// - Jump and call load full 11-bit counter.
`timescale 1ns/100ps

module cfda_core
#(
   parameter int NUM_BANKS = cfda_pkg::NUM_BANKS
)
(
   // Clock and reset.
   input wire logic CLK_SYS_I,
   input wire logic RESET_N_I,
   // Program store.
   output logic [cfda_pkg::PC_W-1:0] ROM_ADDR_O,
   input wire logic [cfda_pkg::IW-1:0] ROM_DATA_I,
   // Special function registers outside the core.
   output cfda_pkg::cfda_sfr_bus_t SFR_BUS_O,
   input wire logic [cfda_pkg::DW-1:0] SFR_RDATA_I,
   // Secondary space write port.
   output cfda_pkg::cfda_sec_wr_t SEC_WR_O,
   // Status of the core.
   output logic FIRST_PHASE_O,
   output logic [cfda_pkg::DW-1:0] ACC_O,
   output logic [cfda_pkg::DW-1:0] STATUS_O,
   output logic [cfda_pkg::DW-1:0] POINTER_O,
   output logic BIT_REFUSED_O
);

   // -------------------------------------------------------------------
   // Sizes and checks
   // -------------------------------------------------------------------
   localparam int DEPTH = NUM_BANKS * cfda_pkg::SRAM_PER_BANK;
   localparam int IDX_W = 8;

   if ((NUM_BANKS < 1) || (NUM_BANKS > 2))
   begin : g_chk
      $error("A single bank select bit serves one or two banks.");
   end

   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------
   cfda_pkg::cfda_phase_t phase_reg;
   cfda_pkg::cfda_phase_t phase_next;
   logic [cfda_pkg::PC_W-1:0] pc_reg;
   logic [cfda_pkg::PC_W-1:0] pc_next;
   logic [cfda_pkg::IW-1:0] ir_reg;
   logic ir_valid_reg;
   logic branch_pending_reg;
   logic [cfda_pkg::PC_W-1:0] target_reg;
   logic [cfda_pkg::DW-1:0] acc_reg;
   logic [cfda_pkg::DW-1:0] acc_next;
   logic [cfda_pkg::DW-1:0] status_reg;
   logic [cfda_pkg::DW-1:0] pointer_reg;
   logic [cfda_pkg::MAIN_AW-1:0] eff_reg;
   cfda_pkg::cfda_sfr_bus_t sfr_reg;
   cfda_pkg::cfda_sec_wr_t sec_reg;
   logic refused_reg;

   // -------------------------------------------------------------------
   // Phase decode
   // -------------------------------------------------------------------
   // Edge that closes the first phase or the second phase.
   wire logic in_first = (phase_reg == cfda_pkg::PH_FIRST);
   wire logic in_second = (phase_reg == cfda_pkg::PH_SECOND);

   // Instruction fields.
   wire logic [2:0] op3 = ir_reg[13:11];
   wire logic [3:0] op4 = ir_reg[13:10];
   wire logic [5:0] op6 = ir_reg[13:8];
   wire logic [cfda_pkg::BIT_IDX_W-1:0] bit_idx = ir_reg[9:7];
   wire logic [cfda_pkg::MAIN_AW-1:0] dir_addr = ir_reg[6:0];
   wire logic [cfda_pkg::DW-1:0] literal = ir_reg[7:0];

   // Instruction classes, only for a word that was not flushed.
   wire logic is_jump = ir_valid_reg &&
      ((op3 == cfda_pkg::OP3_JUMP) || (op3 == cfda_pkg::OP3_CALL));
   wire logic is_bset = ir_valid_reg && (op4 == cfda_pkg::OP4_BSET);
   wire logic is_bclr = ir_valid_reg && (op4 == cfda_pkg::OP4_BCLR);
   wire logic is_btest = ir_valid_reg && (op4 == cfda_pkg::OP4_BTEST);
   wire logic is_bit = is_bset || is_bclr || is_btest;
   wire logic is_store_sec = ir_valid_reg && (op6 == cfda_pkg::OP6_STORE_SEC);
   wire logic is_store_main = ir_valid_reg &&
      (op6 == cfda_pkg::OP6_STORE_MAIN);
   wire logic is_load_main = ir_valid_reg && (op6 == cfda_pkg::OP6_LOAD_MAIN);
   wire logic is_load_lit = ir_valid_reg && (op6 == cfda_pkg::OP6_LOAD_LIT);

   // -------------------------------------------------------------------
   // Main space addressing
   // -------------------------------------------------------------------
   // Bank-relative index into the flip-flop RAM.
   function automatic logic [IDX_W-1:0] sram_index
   (
      input logic bank,
      input logic [cfda_pkg::MAIN_AW-1:0] addr
   );
      logic [IDX_W-1:0] base;
      base = bank ? IDX_W'(cfda_pkg::SRAM_PER_BANK) : 8'h00;
      sram_index = base + IDX_W'(addr - cfda_pkg::SRAM_START);
   endfunction

   // The indirect location itself holds nothing: it stands for the
   // location that the pointer names, resolved in the first phase.
   wire logic dir_is_ind = (dir_addr == cfda_pkg::ADDR_INDIRECT);
   wire logic [cfda_pkg::MAIN_AW-1:0] eff_next = dir_is_ind ?
      pointer_reg[cfda_pkg::MAIN_AW-1:0] : dir_addr;

   // Location classes of the resolved address.
   wire logic hit_ind = (eff_reg == cfda_pkg::ADDR_INDIRECT);
   wire logic hit_status = (eff_reg == cfda_pkg::ADDR_STATUS);
   wire logic hit_pointer = (eff_reg == cfda_pkg::ADDR_POINTER);
   wire logic hit_sram = ({1'b0, eff_reg} >= {1'b0, cfda_pkg::SRAM_START})
      && ({1'b0, eff_reg} < cfda_pkg::SRAM_END);
   wire logic hit_ext = !hit_sram && !hit_ind && !hit_status &&
      !hit_pointer;

   // Bank choice from the status register; a single bank ignores it.
   wire logic bank = (NUM_BANKS > 1) ?
      status_reg[cfda_pkg::BANK_BIT] : 1'b0;
   wire logic [IDX_W-1:0] sram_idx = sram_index(bank, eff_reg);
   wire logic [cfda_pkg::DW-1:0] sram_rdata;

   // Read selection across the main space.
   wire logic [cfda_pkg::DW-1:0] main_rdata =
      hit_sram ? sram_rdata :
      hit_status ? status_reg :
      hit_pointer ? pointer_reg :
      hit_ext ? SFR_RDATA_I : 8'h00;

   // -------------------------------------------------------------------
   // Bit operations
   // -------------------------------------------------------------------
   // Only the lower half of the main space takes bit access.
   wire logic bit_ok = (eff_reg < cfda_pkg::BIT_LIMIT);
   wire logic [cfda_pkg::DW-1:0] bit_mask = 8'h01 << bit_idx;
   wire logic [cfda_pkg::DW-1:0] bit_data = is_bset ?
      (main_rdata | bit_mask) : (main_rdata & ~bit_mask);
   wire logic bit_refused = is_bit && !bit_ok;
   wire logic skip = is_btest && bit_ok &&
      ((main_rdata & bit_mask) == 8'h00);

   // Write to the main space, and its data.
   wire logic main_we = is_store_main ||
      ((is_bset || is_bclr) && bit_ok);
   wire logic [cfda_pkg::DW-1:0] main_wdata = is_store_main ?
      acc_reg : bit_data;
   wire logic exec_we = in_second && main_we && !hit_ind;

   // A jump or a taken skip discards the word fetched beside it.
   wire logic flush = is_jump || skip;

   // -------------------------------------------------------------------
   // Next values
   // -------------------------------------------------------------------
   // Phase toggles on every edge.
   assign phase_next = in_first ?
      cfda_pkg::PH_SECOND : cfda_pkg::PH_FIRST;

   // Counter steps by one or takes the branch target.
   assign pc_next = branch_pending_reg ? target_reg : pc_reg + 11'h001;

   // Accumulator loads.
   assign acc_next = is_load_main ? main_rdata :
      is_load_lit ? literal : acc_reg;

   // -------------------------------------------------------------------
   // Storage of the banked RAM
   // -------------------------------------------------------------------
   cfda_sram
   #(
      .DEPTH(DEPTH),
      .AW(IDX_W)
   )
   u_sram
   (
      .clk_i(CLK_SYS_I),
      .wr_en_i(exec_we && hit_sram),
      .wr_idx_i(sram_idx),
      .wr_data_i(main_wdata),
      .rd_idx_i(sram_idx),
      .rd_data_o(sram_rdata)
   );

   // -------------------------------------------------------------------
   // Sequencing
   // -------------------------------------------------------------------
   // Two-phase divider; reset lands before a second phase edge.
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         phase_reg <= cfda_pkg::PH_SECOND;
      else
         phase_reg <= phase_next;
   end

   // Program counter moves on the first phase edge.
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         pc_reg <= cfda_pkg::RESET_VECTOR;
      else if (in_first)
         pc_reg <= pc_next;
   end

   // Fetch latch; the word is marked dead if a flush is under way.
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         ir_reg <= 14'h0000;
         ir_valid_reg <= 1'b0;
      end
      else if (in_second)
      begin
         ir_reg <= ROM_DATA_I;
         ir_valid_reg <= !flush;
      end
   end

   // Branch target held until the next first phase edge.
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         branch_pending_reg <= 1'b0;
         target_reg <= cfda_pkg::RESET_VECTOR;
      end
      else if (in_second)
      begin
         branch_pending_reg <= is_jump;
         target_reg <= ir_reg[cfda_pkg::PC_W-1:0];
      end
      else
         branch_pending_reg <= 1'b0;
   end

   // Effective address resolved in the first phase of execution.
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         eff_reg <= cfda_pkg::ADDR_INDIRECT;
      else if (in_first)
         eff_reg <= eff_next;
   end

   // -------------------------------------------------------------------
   // Execution in the second phase
   // -------------------------------------------------------------------
   // Accumulator, status and pointer.
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         acc_reg <= 8'h00;
         status_reg <= cfda_pkg::STATUS_RESET;
         pointer_reg <= cfda_pkg::POINTER_RESET;
      end
      else if (in_second)
      begin
         acc_reg <= acc_next;
         if (exec_we && hit_status)
            status_reg <= main_wdata & (8'h01 << cfda_pkg::BANK_BIT);
         if (exec_we && hit_pointer)
            pointer_reg <= main_wdata;
      end
   end

   // Outside registers: address in the first phase, write strobe after.
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         sfr_reg <= '0;
      else if (in_first)
      begin
         sfr_reg.addr <= eff_next;
         sfr_reg.we <= 1'b0;
      end
      else
      begin
         sfr_reg.we <= exec_we && hit_ext;
         sfr_reg.data <= main_wdata;
      end
   end

   // Secondary space is written only; nothing reads it back.
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         sec_reg <= '0;
      else if (in_second && is_store_sec)
      begin
         sec_reg.we <= 1'b1;
         sec_reg.addr <= dir_addr;
         sec_reg.data <= acc_reg;
      end
      else
         sec_reg.we <= 1'b0;
   end

   // One-cycle notice of a refused bit access.
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         refused_reg <= 1'b0;
      else
         refused_reg <= in_second && bit_refused;
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   // Every output is a flip-flop except FIRST_PHASE_O, decoded from the phase register.
   assign ROM_ADDR_O = pc_reg;
   assign SFR_BUS_O = sfr_reg;
   assign SEC_WR_O = sec_reg;
   assign FIRST_PHASE_O = in_first;
   assign ACC_O = acc_reg;
   assign STATUS_O = status_reg;
   assign POINTER_O = pointer_reg;
   assign BIT_REFUSED_O = refused_reg;

endmodule

// [core/cfda_pkg.sv]
// Package for the fetch and data addressing core: widths, map, opcodes.
// Assumes a combinational program store and an external block of special
// function registers on the same clock.
package cfda_pkg;

   // ------------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------------
   localparam int PC_W = 11;
   localparam int IW = 14;
   localparam int DW = 8;
   localparam int MAIN_AW = 7;
   localparam int SEC_AW = 7;
   localparam int BIT_IDX_W = 3;

   // ------------------------------------------------------------------
   // Main data space map
   // ------------------------------------------------------------------
   localparam logic [MAIN_AW-1:0] ADDR_INDIRECT = 7'h00;
   localparam logic [MAIN_AW-1:0] ADDR_STATUS = 7'h03;
   localparam logic [MAIN_AW-1:0] ADDR_POINTER = 7'h04;
   localparam logic [MAIN_AW-1:0] SRAM_START = 7'h20;
   localparam logic [MAIN_AW:0] SRAM_END = 8'h80;
   localparam logic [MAIN_AW-1:0] BIT_LIMIT = 7'h40;
   localparam int BANK_BIT = 5;
   localparam int NUM_BANKS = 2;
   localparam int SRAM_PER_BANK = 96;
   localparam logic [PC_W-1:0] RESET_VECTOR = 11'h000;
   localparam logic [DW-1:0] STATUS_RESET = 8'h00;
   localparam logic [DW-1:0] POINTER_RESET = 8'h00;

   // ------------------------------------------------------------------
   // Instruction encoding
   // ------------------------------------------------------------------
   localparam logic [2:0] OP3_JUMP = 3'h4;
   localparam logic [2:0] OP3_CALL = 3'h5;
   localparam logic [3:0] OP4_BSET = 4'hC;
   localparam logic [3:0] OP4_BCLR = 4'hD;
   localparam logic [3:0] OP4_BTEST = 4'hE;
   localparam logic [5:0] OP6_STORE_SEC = 6'h01;
   localparam logic [5:0] OP6_STORE_MAIN = 6'h02;
   localparam logic [5:0] OP6_LOAD_MAIN = 6'h03;
   localparam logic [5:0] OP6_LOAD_LIT = 6'h04;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [1:0]
   {
      PH_FIRST = 2'h1,
      PH_SECOND = 2'h2
   } cfda_phase_t;

   typedef struct packed {
      logic we;
      logic [SEC_AW-1:0] addr;
      logic [DW-1:0] data;
   } cfda_sec_wr_t;

   typedef struct packed {
      logic we;
      logic [MAIN_AW-1:0] addr;
      logic [DW-1:0] data;
   } cfda_sfr_bus_t;

endpackage

// [core/cfda_sram.sv]
// Flip-flop storage for the banked general purpose RAM.
// Assumes one write port and one combinational read port on one clock.
`timescale 1ns/100ps

module cfda_sram
#(
   parameter int DEPTH = 192,
   parameter int AW = 8
)
(
   // Clock.
   input wire logic clk_i,
   // Write port.
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_idx_i,
   input wire logic [cfda_pkg::DW-1:0] wr_data_i,
   // Read port.
   input wire logic [AW-1:0] rd_idx_i,
   output logic [cfda_pkg::DW-1:0] rd_data_o
);

   // -------------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------------
   logic [cfda_pkg::DW-1:0] mem_reg [DEPTH];

   if (DEPTH > (1 << AW))
   begin : g_chk
      $error("Index width too small for the RAM depth.");
   end

   // One write-enabled byte per location.
   for (genvar i = 0; i < DEPTH; i++)
   begin : g_cell
      always_ff @(posedge clk_i)
      begin
         if (wr_en_i && (wr_idx_i == AW'(i)))
            mem_reg[i] <= wr_data_i;
      end
   end

   // Out-of-range reads return zero.
   assign rd_data_o = (int'(rd_idx_i) < DEPTH) ? mem_reg[rd_idx_i] : 8'h00;

endmodule

// [tb/cfda_core_properties.sv]
// Concurrent checks on the fetch and data addressing core.
// Assumes a bind onto cfda_core and one clock domain.
`timescale 1ns/100ps

module cfda_core_checker
#(
   parameter int NUM_BANKS = 2
)
(
   // Clock and reset.
   input wire logic CLK_SYS_I,
   input wire logic RESET_N_I,
   // Program store.
   input wire logic [cfda_pkg::PC_W-1:0] ROM_ADDR_O,
   input wire logic [cfda_pkg::IW-1:0] ROM_DATA_I,
   // Outside registers and secondary space.
   input wire cfda_pkg::cfda_sfr_bus_t SFR_BUS_O,
   input wire cfda_pkg::cfda_sec_wr_t SEC_WR_O,
   // Status of the core.
   input wire logic FIRST_PHASE_O,
   input wire logic [cfda_pkg::DW-1:0] ACC_O,
   input wire logic [cfda_pkg::DW-1:0] STATUS_O,
   input wire logic BIT_REFUSED_O
);
   logic prev_jump_reg;

   // Remembers whether the word fetched last was a branch.
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         prev_jump_reg <= 1'b0;
      else if (!FIRST_PHASE_O)
         prev_jump_reg <= (ROM_DATA_I[13:12] == 2'h2);
   end

   // A fetch is live when the word before it was not a branch.
   wire logic live = !FIRST_PHASE_O && !prev_jump_reg;
   wire logic [5:0] op6 = ROM_DATA_I[13:8];
   wire logic [6:0] fa = ROM_DATA_I[6:0];
   wire logic jump = ROM_DATA_I[13:12] == 2'h2;
   wire logic bit_op = ROM_DATA_I[13:12] == 2'h3 && ROM_DATA_I[11:10] != 2'h3;

   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RESET_N_I);

   a_phase_toggle: assert property ($past(RESET_N_I) |->
      FIRST_PHASE_O != $past(FIRST_PHASE_O)) else $error("phase stuck");
   a_pc_first_phase: assert property (ROM_ADDR_O != $past(ROM_ADDR_O)
      |-> $past(FIRST_PHASE_O)) else $error("counter moved late");
   a_jump_target: assert property (live && jump |-> ##4
      ROM_ADDR_O == $past(ROM_DATA_I[10:0], 4)) else $error("bad target");
   a_flush_quiet: assert property (live && jump |-> ##5
      !(SEC_WR_O.we || SFR_BUS_O.we || BIT_REFUSED_O))
      else $error("flushed word acted");
   a_sec_store: assert property (live && op6 == 6'h01 |-> ##3
      SEC_WR_O.we && SEC_WR_O.addr == $past(fa, 3)
      && SEC_WR_O.data == $past(ACC_O)) else $error("bad store");
   a_sec_cause: assert property (SEC_WR_O.we |->
      $past(op6, 3) == 6'h01) else $error("stray secondary write");
   a_bit_refused: assert property (live && bit_op && fa[6] |->
      ##3 BIT_REFUSED_O) else $error("upper bit op taken");
   a_bit_lower: assert property (bit_op && !fa[6] && fa != 7'h00
      |-> ##3 !BIT_REFUSED_O) else $error("lower bit op refused");
   a_bank_bit: assert property (live && bit_op && !ROM_DATA_I[11]
      && ROM_DATA_I[9:0] == {3'h5, 7'h03} |-> ##3
      STATUS_O[5] == !$past(ROM_DATA_I[10], 3)) else $error("bank bit");
   a_sfr_store: assert property (live && op6 == 6'h02
      && fa[6:4] == 3'h1 |-> ##3 SFR_BUS_O.we
      && SFR_BUS_O.addr == $past(fa, 3) && SFR_BUS_O.data == $past(ACC_O))
      else $error("register write lost");
   a_sram_local: assert property (op6 == 6'h02 && fa[6:5] != 2'h0
      |-> ##3 !SFR_BUS_O.we) else $error("ram write leaked");
endmodule

bind cfda_core cfda_core_checker #(.NUM_BANKS(NUM_BANKS)) u_chk
(
   .CLK_SYS_I(CLK_SYS_I),
   .RESET_N_I(RESET_N_I),
   .ROM_ADDR_O(ROM_ADDR_O),
   .ROM_DATA_I(ROM_DATA_I),
   .SFR_BUS_O(SFR_BUS_O),
   .SEC_WR_O(SEC_WR_O),
   .FIRST_PHASE_O(FIRST_PHASE_O),
   .ACC_O(ACC_O),
   .STATUS_O(STATUS_O),
   .BIT_REFUSED_O(BIT_REFUSED_O)
);

// [tb/cfda_rom_model.sv]
// Program store and outside special register model for the core.
// Assumes the bench loads program words before reset is released.
`timescale 1ns/100ps

module cfda_rom_model
(
   // Clock.
   input wire logic clk_i,
   // Program store.
   input wire logic [cfda_pkg::PC_W-1:0] rom_addr_i,
   output logic [cfda_pkg::IW-1:0] rom_data_o,
   // Outside special registers.
   input wire cfda_pkg::cfda_sfr_bus_t sfr_bus_i,
   output logic [cfda_pkg::DW-1:0] sfr_rdata_o
);
   logic [cfda_pkg::IW-1:0] rom_mem [2048];
   logic [cfda_pkg::DW-1:0] sfr_mem [32];

   // Unused words read as no-ops; registers start cleared.
   initial
   begin
      foreach (rom_mem[i])
         rom_mem[i] = 14'h0000;
      foreach (sfr_mem[i])
         sfr_mem[i] = 8'h00;
   end

   // The word at the current address is offered at once.
   assign rom_data_o = rom_mem[rom_addr_i];
   // The low main addresses answer from this register block.
   assign sfr_rdata_o = sfr_mem[sfr_bus_i.addr[4:0]];

   // A write pulse stores one byte into the addressed register.
   always @(posedge clk_i)
   begin
      if (sfr_bus_i.we)
         sfr_mem[sfr_bus_i.addr[4:0]] <= sfr_bus_i.data;
   end
endmodule

// [tb/cpu_fetch_and_data_addressing_tb_top.sv]
// Self-checking bench for the fetch and data addressing core.
// Assumes the checker bind and the program store model.
`timescale 1ns/100ps

`define CHK(nm, ex, sn) \
   begin \
      compares++; \
      if ((sn) !== (ex)) \
      begin \
         n_fail++; \
         $display("wrong value %s expected %h seen %h", nm, ex, sn); \
      end \
   end

module cpu_fetch_and_data_addressing_tb_top;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic [10:0] rom_addr;
   logic [13:0] rom_data;
   cfda_pkg::cfda_sfr_bus_t sfr_bus;
   logic [7:0] sfr_rdata;
   cfda_pkg::cfda_sec_wr_t sec_wr;
   logic first_phase;
   logic bit_refused;
   logic [7:0] acc;
   logic [7:0] status;
   logic [7:0] pointer;
   logic [15:0] exp_q [$];
   logic [15:0] got;
   logic [15:0] exp;
   logic [13:0] prog [24];
   logic [13:0] far_prog [9];
   logic [7:0] v;
   logic [7:0] w;
   int n_fail = 0;
   int compares = 0;

   // Clock of 40 ns period.
   always #20 clk_sys = ~clk_sys;

   cfda_core dut
   (
      .CLK_SYS_I(clk_sys),
      .RESET_N_I(reset_n),
      .ROM_ADDR_O(rom_addr),
      .ROM_DATA_I(rom_data),
      .SFR_BUS_O(sfr_bus),
      .SFR_RDATA_I(sfr_rdata),
      .SEC_WR_O(sec_wr),
      .FIRST_PHASE_O(first_phase),
      .ACC_O(acc),
      .STATUS_O(status),
      .POINTER_O(pointer),
      .BIT_REFUSED_O(bit_refused)
   );

   cfda_rom_model partner
   (
      .clk_i(clk_sys),
      .rom_addr_i(rom_addr),
      .rom_data_o(rom_data),
      .sfr_bus_i(sfr_bus),
      .sfr_rdata_o(sfr_rdata)
   );

   // Prints the counts and the verdict, then stops.
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Records one expected write: kind, address, data.
   task automatic note(input logic k, input logic [6:0] a,
                       input logic [7:0] d);
      exp_q.push_back({k, a, d});
   endtask

   // Takes the oldest note whenever the core reports an effect.
   always @(negedge clk_sys)
   begin
      if (reset_n && (sec_wr.we || sfr_bus.we || bit_refused))
      begin
         got = bit_refused ? 16'hFFFF : sec_wr.we ?
            {1'b0, sec_wr.addr, sec_wr.data} :
            {1'b1, sfr_bus.addr, sfr_bus.data};
         exp = (exp_q.size() != 0) ? exp_q.pop_front() : 16'hDEAD;
         `CHK("write event", exp, got)
      end
   end

   // Program: stores, indirect and banked loads, bit ops, skips, branches.
   initial
   begin
      #1;
      void'($urandom(59760));
      v = 8'($urandom());
      w = 8'($urandom());
      prog = '{{6'h04, v}, 14'h0105, 14'h0220, 14'h0420, 14'h0204,
         14'h0400, 14'h0300, 14'h0106, 14'h3283, {6'h04, w}, 14'h0220,
         14'h3683, 14'h0320, 14'h0107, 14'h3040, 14'h0210, 14'h0400,
         14'h0310, 14'h0108, 14'h3283, 14'h0320, 14'h0109, 14'h2400,
         14'h010A};
      foreach (prog[i])
         partner.rom_mem[i] = prog[i];
      far_prog = '{14'h010B, 14'h3803, {6'h04, ~w}, 14'h3A83, 14'h010D,
         14'h2C07, 14'h010E, 14'h010F, 14'h2408};
      foreach (far_prog[i])
         partner.rom_mem[11'h400 + i] = far_prog[i];
      note(1'b0, 7'h05, v);
      note(1'b0, 7'h06, v);
      note(1'b0, 7'h07, v);
      exp_q.push_back(16'hFFFF);
      note(1'b1, 7'h10, v);
      note(1'b0, 7'h08, v);
      note(1'b0, 7'h09, w);
      note(1'b0, 7'h0B, w);
      note(1'b0, 7'h0D, w);
      note(1'b0, 7'h0F, w);
      repeat (2) @(posedge clk_sys);
      #1 reset_n = 1'b1;
      for (int i = 0; i < 300 && exp_q.size() != 0; i++)
         @(posedge clk_sys);
      repeat (20) @(posedge clk_sys);
      `CHK("notes left", 0, exp_q.size())
      `CHK("pointer", 8'h20, pointer)
      `CHK("bank select", 8'h20, status)
      $display("test program finished");
      print_verdict();
   end

   // The program needs about 90 cycles; 1000 cycles means a hang.
   initial
   begin
      #40000;
      n_fail++;
      print_verdict();
   end
endmodule
